// ===== include/srsc_defines.svh
// timing constants of the safety relay state controller
`ifndef SRSC_DEFINES_SVH
`define SRSC_DEFINES_SVH

`define SRSC_CLK_HZ 20000000
`define SRSC_CLK_PER_MS (`SRSC_CLK_HZ / 1000)

// interlock monitoring window, in ms
`define SRSC_ILK_WINDOW_MS 200
`define SRSC_ILK_WINDOW_CYC (`SRSC_ILK_WINDOW_MS * `SRSC_CLK_PER_MS)

// quiet time needed to leave an interlock condition, in ms
`define SRSC_ILK_QUIET_MS 1000
`define SRSC_ILK_QUIET_CYC (`SRSC_ILK_QUIET_MS * `SRSC_CLK_PER_MS)

// defaults for times that are configuration dependent, in cycles
`define SRSC_ACT_DELAY_CYC 16
`define SRSC_SYNC_CYC 64
`define SRSC_RESP_CYC 2

`endif

// ===== include/srsc_pkg.sv
// types of the safety relay state controller
package srsc_pkg;

  typedef enum logic [4:0] {
    SRSC_INIT = 5'h01,
    SRSC_OFF = 5'h02,
    SRSC_ARM = 5'h04,
    SRSC_ON = 5'h08,
    SRSC_ERR = 5'h10
  } srsc_state_t;

endpackage

// ===== logic/srsc_timer.sv
// saturating cycle timer that runs while its enable is held
`timescale 1ns/100ps
module srsc_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [31:0] limit,
  output logic expired
);

  logic [31:0] count;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 32'h0;
    end else if (!run) begin
      count <= 32'h0;
    end else if (count != limit) begin
      count <= count + 32'h1;
    end
  end

  // high once run has been held for limit cycles
  assign expired = run && (count == limit);

endmodule

// ===== logic/srsc_ctrl.sv
// operating-state controller of a safety relay module
`timescale 1ns/100ps
`include "srsc_defines.svh"

// Operation
// - power-up enters initialization, outputs off
// - successful init moves to deenergized run
// - any error goes to safe error state
// - deenergized run evaluates safety and start inputs
// - no start keeps outputs deenergized
// - start without safety inputs stays deenergized
// - start plus safety inputs energizes outputs
// - synchronization time must be met to energize
// - deactivation drops outputs within response time
// - one channel dropping suffices to deenergize
// - re-energize needs fresh start and inputs
// - interlock condition blocks energizing
// - output activates within activation delay; here safetyOut rises ACT_DELAY_CYC + 1 cycles after SRSC_ARM entry
// - first channel alone never energizes
// - 200 ms window, then interlock alert
// - one second both off clears interlock
module srsc_ctrl #(
  parameter logic [31:0] ACT_DELAY_CYC = `SRSC_ACT_DELAY_CYC,
  parameter logic [31:0] SYNC_CYC = `SRSC_SYNC_CYC,
  parameter logic [31:0] RESP_CYC = `SRSC_RESP_CYC,
  parameter logic [31:0] ILK_WINDOW_CYC = `SRSC_ILK_WINDOW_CYC,
  parameter logic [31:0] ILK_QUIET_CYC = `SRSC_ILK_QUIET_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chanA,
  input wire logic chanB,
  input wire logic startIn,
  input wire logic selfTestDone,
  input wire logic selfTestPass,
  input wire logic faultIn,
  input wire logic syncEnable,
  input wire logic interlockEnable,
  output logic safetyOut,
  output logic safeState,
  output logic [4:0] stateCode,
  output logic interlockAlert,
  output logic syncFault,
  output logic errorFlag
);

  srsc_pkg::srsc_state_t state;
  srsc_pkg::srsc_state_t next_state;

  logic bothOn;
  logic bothOff;
  logic oneOn;
  logic bothPrev;
  logic startReleased;
  logic ilkWatch;
  logic ilkExpired;
  logic quietExpired;
  logic syncExpired;
  logic actExpired;
  logic errorNow;
  logic energizeOk;

  assign bothOn = chanA && chanB;
  assign bothOff = !chanA && !chanB;
  assign oneOn = chanA ^ chanB;
  assign errorNow = faultIn || (state == srsc_pkg::SRSC_INIT && selfTestDone && !selfTestPass);

  // fresh start, both channels, no interlock and no sync fault
  assign energizeOk = startIn && startReleased && bothOn && !interlockAlert && !syncFault;

  // one channel only for too long
  srsc_timer u_sync_timer (
    .clk(clk),
    .reset_n(reset_n),
    .run(syncEnable && oneOn),
    .limit(SYNC_CYC),
    .expired(syncExpired)
  );

  // interlock window from the first channel's drop
  srsc_timer u_ilk_timer (
    .clk(clk),
    .reset_n(reset_n),
    .run(ilkWatch),
    .limit(ILK_WINDOW_CYC),
    .expired(ilkExpired)
  );

  // both channels off while the alert stands
  srsc_timer u_quiet_timer (
    .clk(clk),
    .reset_n(reset_n),
    .run(interlockAlert && bothOff),
    .limit(ILK_QUIET_CYC),
    .expired(quietExpired)
  );

  // activation delay before energizing
  srsc_timer u_act_timer (
    .clk(clk),
    .reset_n(reset_n),
    .run(state == srsc_pkg::SRSC_ARM),
    .limit(ACT_DELAY_CYC),
    .expired(actExpired)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      srsc_pkg::SRSC_INIT: begin
        if (errorNow) begin
          next_state = srsc_pkg::SRSC_ERR;
        end else if (selfTestDone && selfTestPass) begin
          next_state = srsc_pkg::SRSC_OFF;
        end
      end
      srsc_pkg::SRSC_OFF: begin
        if (errorNow) begin
          next_state = srsc_pkg::SRSC_ERR;
        end else if (energizeOk) begin
          next_state = srsc_pkg::SRSC_ARM;
        end
      end
      srsc_pkg::SRSC_ARM: begin
        if (errorNow) begin
          next_state = srsc_pkg::SRSC_ERR;
        end else if (!bothOn || interlockAlert || syncFault) begin
          next_state = srsc_pkg::SRSC_OFF;
        end else if (actExpired) begin
          next_state = srsc_pkg::SRSC_ON;
        end
      end
      srsc_pkg::SRSC_ON: begin
        if (errorNow) begin
          next_state = srsc_pkg::SRSC_ERR;
        end else if (!bothOn) begin
          next_state = srsc_pkg::SRSC_OFF;
        end
      end
      srsc_pkg::SRSC_ERR: begin
        next_state = srsc_pkg::SRSC_ERR;
      end
      default: begin
        next_state = srsc_pkg::SRSC_ERR;
      end
    endcase
  end

  // reset acts as power-on: initialization first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= srsc_pkg::SRSC_INIT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      safetyOut <= 1'b0;
      safeState <= 1'b1;
      stateCode <= 5'h01;
    end else begin
      safetyOut <= (next_state == srsc_pkg::SRSC_ON);
      safeState <= (next_state != srsc_pkg::SRSC_ON);
      stateCode <= next_state;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      errorFlag <= 1'b0;
    end else if (next_state == srsc_pkg::SRSC_ERR) begin
      errorFlag <= 1'b1;
    end
  end

  // start must be seen released before each energize
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      startReleased <= 1'b0;
    end else if (!startIn) begin
      startReleased <= 1'b1;
    end else if (next_state == srsc_pkg::SRSC_ARM) begin
      startReleased <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncFault <= 1'b0;
    end else if (syncExpired) begin
      syncFault <= 1'b1;
    end else if (bothOff || !syncEnable) begin
      syncFault <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bothPrev <= 1'b0;
    end else begin
      bothPrev <= bothOn;
    end
  end

  // window opens when one of two active channels drops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ilkWatch <= 1'b0;
    end else if (!interlockEnable || bothOff || ilkExpired || bothOn) begin
      ilkWatch <= 1'b0;
    end else if (bothPrev && oneOn) begin
      ilkWatch <= 1'b1;
    end
  end

  // expiry or reactivation of the first channel raises the alert
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      interlockAlert <= 1'b0;
    end else if (ilkWatch && (ilkExpired || bothOn)) begin
      interlockAlert <= 1'b1;
    end else if (quietExpired) begin
      interlockAlert <= 1'b0;
    end
  end

  logic [31:0] offCount;

  // cycles from a channel drop in ON until the output is off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      offCount <= 32'h0;
    end else if (safetyOut && !bothOn) begin
      offCount <= offCount + 32'h1;
    end else begin
      offCount <= 32'h0;
    end
  end

  a_init_outputs_off: assert property (@(posedge clk) disable iff (!reset_n)
    (state == srsc_pkg::SRSC_INIT) |-> !safetyOut && safeState)
    else $error("output energized during initialization");

  a_init_to_run: assert property (@(posedge clk) disable iff (!reset_n)
    (state == srsc_pkg::SRSC_INIT && selfTestDone && selfTestPass && !faultIn)
    |=> (state == srsc_pkg::SRSC_OFF) && !safetyOut)
    else $error("successful init did not reach deenergized run");

  a_error_safe: assert property (@(posedge clk) disable iff (!reset_n)
    faultIn |=> (state == srsc_pkg::SRSC_ERR) && !safetyOut && errorFlag)
    else $error("error not followed by safe error state");

  a_no_start_off: assert property (@(posedge clk) disable iff (!reset_n)
    (state == srsc_pkg::SRSC_OFF && !startIn) |=> (state != srsc_pkg::SRSC_ARM) && !safetyOut)
    else $error("left deenergized run without start");

  a_inputs_low_off: assert property (@(posedge clk) disable iff (!reset_n)
    (state == srsc_pkg::SRSC_OFF && startIn && !bothOn && !faultIn) |=> (state == srsc_pkg::SRSC_OFF))
    else $error("armed with safety inputs not active");

  a_energize_arm: assert property (@(posedge clk) disable iff (!reset_n)
    (state == srsc_pkg::SRSC_OFF && energizeOk && !faultIn) |=> (state == srsc_pkg::SRSC_ARM))
    else $error("start and inputs active but not armed");

  a_act_delay_on: assert property (@(posedge clk) disable iff (!reset_n)
    (state == srsc_pkg::SRSC_ARM && actExpired && bothOn && !interlockAlert && !syncFault && !faultIn)
    |=> safetyOut)
    else $error("output not energized after activation delay");

  a_sync_block: assert property (@(posedge clk) disable iff (!reset_n)
    (syncFault && state != srsc_pkg::SRSC_ON) |=> !safetyOut)
    else $error("energized despite synchronization fault");

  a_drop_resp: assert property (@(posedge clk) disable iff (!reset_n)
    offCount < RESP_CYC)
    else $error("output not off within response time");

  a_one_chan_drop: assert property (@(posedge clk) disable iff (!reset_n)
    (safetyOut && (chanA != chanB)) |=> !safetyOut ##0 (state != srsc_pkg::SRSC_ON))
    else $error("single channel drop did not deenergize");

  a_rearm_start: assert property (@(posedge clk) disable iff (!reset_n)
    (state == srsc_pkg::SRSC_OFF && !startReleased) |=> (state != srsc_pkg::SRSC_ARM))
    else $error("re-energized without fresh start");

  a_ilk_block: assert property (@(posedge clk) disable iff (!reset_n)
    (state == srsc_pkg::SRSC_OFF && interlockAlert) |=> (state != srsc_pkg::SRSC_ARM))
    else $error("armed during interlock condition");

  a_first_chan_only: assert property (@(posedge clk) disable iff (!reset_n)
    (!safetyOut && (chanA != chanB)) |=> !safetyOut)
    else $error("single channel energized output");

  a_ilk_window: assert property (@(posedge clk) disable iff (!reset_n)
    (ilkWatch && ilkExpired) |=> interlockAlert)
    else $error("interlock window expired without alert");

  a_ilk_clear: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(interlockAlert) |-> $past(quietExpired) && $past(bothOff))
    else $error("interlock cleared without quiet time");

  c_energize: cover property (@(posedge clk) disable iff (!reset_n) $rose(safetyOut));
  c_drop: cover property (@(posedge clk) disable iff (!reset_n) $fell(safetyOut));
  c_ilk_alert: cover property (@(posedge clk) disable iff (!reset_n) $rose(interlockAlert));
  c_error: cover property (@(posedge clk) disable iff (!reset_n) $rose(errorFlag));

endmodule

// ===== test/srsc_contact_model.sv
// contact and start button model facing the state controller
`timescale 1ns/100ps
module srsc_contact_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wantA,
  input wire logic wantB,
  input wire logic wantStart,
  output logic chanA,
  output logic chanB,
  output logic startIn
);
  // contacts open at power-up, each follows its request one edge later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chanA <= 1'b0;
      chanB <= 1'b0;
      startIn <= 1'b0;
    end else begin
      chanA <= wantA;
      chanB <= wantB;
      startIn <= wantStart;
    end
  end
endmodule

// ===== test/tb.sv
// self-checking bench of the safety relay state controller
`timescale 1ns/100ps
module tb;
  localparam int ACT = 4;
  localparam int SYN = 10;
  localparam int RSP = 2;
  localparam int WIN = 20;
  localparam int QUI = 50;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wantA = 1'b0;
  logic wantB = 1'b0;
  logic wantStart = 1'b0;
  logic stDone = 1'b0;
  logic stPass = 1'b0;
  logic faultIn = 1'b0;
  logic syncEnable = 1'b0;
  logic interlockEnable = 1'b0;
  logic chanA, chanB, startIn, safetyOut, safeState, interlockAlert, syncFault, errorFlag;
  logic [4:0] stateCode;
  int failures = 0;
  int checksDone = 0;

  always #25 clk = ~clk;

  srsc_contact_model u_srsc_contact_model (.clk(clk), .reset_n(reset_n), .wantA(wantA), .wantB(wantB),
    .wantStart(wantStart), .chanA(chanA), .chanB(chanB), .startIn(startIn));

  srsc_ctrl #(.ACT_DELAY_CYC(32'h4), .SYNC_CYC(32'hA), .RESP_CYC(32'h2), .ILK_WINDOW_CYC(32'h14),
    .ILK_QUIET_CYC(32'h32)) u_srsc_ctrl (.clk(clk), .reset_n(reset_n), .chanA(chanA), .chanB(chanB),
    .startIn(startIn), .selfTestDone(stDone), .selfTestPass(stPass), .faultIn(faultIn),
    .syncEnable(syncEnable), .interlockEnable(interlockEnable), .safetyOut(safetyOut),
    .safeState(safeState), .stateCode(stateCode), .interlockAlert(interlockAlert),
    .syncFault(syncFault), .errorFlag(errorFlag));

  task automatic summarize;
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic setIn(input logic a, input logic b, input logic s);
    wantA = a;
    wantB = b;
    wantStart = s;
  endtask

  // fresh start with both channels, then waits a bounded time for the output
  task automatic energize(input logic expOn);
    int n;
    setIn(1'b1, 1'b1, 1'b0);
    tick(3);
    setIn(1'b1, 1'b1, 1'b1);
    n = 0;
    while (safetyOut !== 1'b1 && n < ACT + 6) begin
      tick(1);
      n++;
    end
    check({4'h0, safetyOut}, {4'h0, expOn});
    check({4'h0, safeState}, {4'h0, ~expOn});
    if (expOn) begin
      check({4'h0, n <= ACT + 3}, 5'h01);
    end
  endtask

  task automatic t_reset;
    tick(1);
    check(stateCode, 5'h01);
    check({4'h0, safetyOut}, 5'h00);
    tick(9);
    reset_n = 1'b1;
    tick(4);
    check(stateCode, 5'h01);
    stDone = 1'b1;
    stPass = 1'b1;
    tick(2);
    check(stateCode, 5'h02);
    check({4'h0, safeState}, 5'h01);
  endtask

  task automatic t_idle;
    setIn(1'b0, 1'b0, 1'b1);
    tick(8);
    check(stateCode, 5'h02);
    setIn(1'b1, 1'b1, 1'b0);
    tick(8);
    check(stateCode, 5'h02);
    setIn(1'b1, 1'b0, 1'b0);
    tick(3);
    setIn(1'b1, 1'b0, 1'b1);
    tick(8);
    check(stateCode, 5'h02);
    setIn(1'b0, 1'b0, 1'b0);
    tick(4);
  endtask

  task automatic t_run;
    int n;
    energize(1'b1);
    check(stateCode, 5'h08);
    setIn(1'b1, 1'b0, 1'b1);
    n = 0;
    while (safetyOut !== 1'b0 && n < 10) begin
      tick(1);
      n++;
    end
    check({4'h0, n <= RSP + 2}, 5'h01);
    check(stateCode, 5'h02);
    setIn(1'b1, 1'b1, 1'b1);
    tick(8);
    check(stateCode, 5'h02);
    setIn(1'b1, 1'b1, 1'b0);
    tick(8);
    check(stateCode, 5'h02);
    energize(1'b1);
    setIn(1'b0, 1'b0, 1'b0);
    tick(4);
  endtask

  task automatic t_sync;
    syncEnable = 1'b1;
    setIn(1'b1, 1'b0, 1'b0);
    tick(SYN + 5);
    check({4'h0, syncFault}, 5'h01);
    setIn(1'b1, 1'b1, 1'b1);
    tick(10);
    check({4'h0, safetyOut}, 5'h00);
    setIn(1'b0, 1'b0, 1'b0);
    tick(4);
    check({4'h0, syncFault}, 5'h00);
    setIn(1'b1, 1'b0, 1'b0);
    tick(SYN - 5);
    energize(1'b1);
    setIn(1'b0, 1'b0, 1'b0);
    tick(4);
    syncEnable = 1'b0;
  endtask

  task automatic t_ilk;
    interlockEnable = 1'b1;
    energize(1'b1);
    setIn(1'b0, 1'b1, 1'b0);
    tick(5);
    setIn(1'b0, 1'b0, 1'b0);
    tick(4);
    check({4'h0, interlockAlert}, 5'h00);
    energize(1'b1);
    setIn(1'b0, 1'b1, 1'b0);
    tick(WIN - 2);
    check({4'h0, interlockAlert}, 5'h00);
    tick(7);
    check({4'h0, interlockAlert}, 5'h01);
    energize(1'b0);
    setIn(1'b0, 1'b0, 1'b0);
    tick(QUI - 10);
    check({4'h0, interlockAlert}, 5'h01);
    tick(15);
    check({4'h0, interlockAlert}, 5'h00);
    energize(1'b1);
    setIn(1'b0, 1'b1, 1'b0);
    tick(4);
    setIn(1'b1, 1'b1, 1'b0);
    tick(3);
    check({4'h0, interlockAlert}, 5'h01);
    setIn(1'b0, 1'b0, 1'b0);
    tick(QUI + 5);
    interlockEnable = 1'b0;
  endtask

  task automatic t_err;
    energize(1'b1);
    faultIn = 1'b1;
    tick(2);
    faultIn = 1'b0;
    check(stateCode, 5'h10);
    check({3'h0, errorFlag, safetyOut}, 5'h02);
    tick(4);
    check(stateCode, 5'h10);
    stPass = 1'b0;
    reset_n = 1'b0;
    tick(1);
    reset_n = 1'b1;
    tick(4);
    check(stateCode, 5'h10);
  endtask

  initial begin
    #200000;
    failures++;
    summarize();
  end

  initial begin
    t_reset();
    t_idle();
    t_run();
    t_sync();
    t_ilk();
    t_err();
    summarize();
  end
endmodule
